/* verilog/scrc_top.sv */
// System channel selection, relay drive and simulated module slots
// Functional notes
// - Channel code is three BCD digits: slot, then two-digit channel.
// - Remote assign command gives slots 1 to 5 a simulated module type.
// - Assigning to a slot holding a physical module is refused.
// - A simulated module lights that slot's occupancy lamp.
// - Simulated assignments are volatile and cleared at power-off reset.
// - Assignment accepted only from the remote path, never front panel.
// - At most one system channel; nothing displayed means none selected.
// - Closing a measurement channel also closes input isolation relay.
// - Four-wire close adds paired channel and sense isolation relay.
// - A new close opens the previous system channel and replaces it.
// - Close requests on non-measurement channels are rejected, nothing closes.
// - Twenty-channel module: system channels 1 to 20, 1 to 10 in four-wire, pair is n plus ten.
// - Input isolation relay is channel 25, sense isolation is 24.
// - Four-wire mode also closes channel 23 to split the pair.
// - Trigger starts one measurement on system channel, result displayed.
// - Display shows the system channel, never the paired channel.
// - Open-all opens every relay in every slot, no system channel.
// - Invalid remote close raises parameter range error -222.
`default_nettype none
module scrc_top
  import scrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [SLOTS*TYPE_W-1:0] phys_type_pin,
  input wire logic four_wire,
  input wire logic cmd_valid,
  input wire logic cmd_remote,
  input wire logic [OP_W-1:0] cmd_op,
  input wire logic [CODE_W-1:0] slot_channel_code,
  input wire logic [TYPE_W-1:0] cmd_sim_type,
  input wire logic trigger,
  input wire logic meas_done,
  input wire logic [VAL_W-1:0] meas_value,
  output wire logic [SLOTS*RELAY_N-1:0] relay_on,
  output logic [SLOTS-1:0] slot_lamp_r,
  output logic disp_chan_valid_r,
  output logic [CODE_W-1:0] disp_chan_r,
  output logic disp_value_valid_r,
  output logic [VAL_W-1:0] disp_value_r,
  output logic meas_start_r,
  output logic [CODE_W-1:0] meas_chan_r,
  output logic cmd_done_r,
  output logic cmd_reject_r,
  output logic err_valid_r,
  output logic [ERR_W-1:0] err_code_r
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Two BCD digits to a binary channel number
  function automatic logic [CH_W-1:0] bcd_chan(input logic [7:0] d);
    logic [CH_W-1:0] tens;
    tens = {3'h0, d[7:4]};
    // Tens times ten as two shifts, so no multiplier is built
    bcd_chan = 7'((tens << 3) + (tens << 1) + {3'h0, d[3:0]});
  endfunction

  // Slot digit in range 1 to 5
  function automatic logic slot_ok(input logic [3:0] d);
    slot_ok = (d >= SLOT_FIRST) && (d <= SLOT_LAST);
  endfunction

  // Zero-based slot index for the per-slot tables
  function automatic logic [2:0] slot_idx(input logic [3:0] d);
    slot_idx = 3'(d - SLOT_FIRST);
  endfunction

  // ----------------------------------------------------------------
  // Reset release synchroniser
  // ----------------------------------------------------------------
  // Two release stages; only the second one resets the logic
  logic rst_meta_r;
  logic rst_sync_n_r;

  // Release is synchronised so every flop leaves reset on the same edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Physical module presence pins
  // ----------------------------------------------------------------
  // Presence pins come from the slots and are not on this clock
  logic [SLOTS*TYPE_W-1:0] phys_meta_r;
  logic [SLOTS*TYPE_W-1:0] phys_sync_r;

  // Two-flop synchroniser; only the second stage is read
  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      phys_meta_r <= '0;
      phys_sync_r <= '0;
    end else begin
      phys_meta_r <= phys_type_pin;
      phys_sync_r <= phys_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Command field decode
  // ----------------------------------------------------------------
  // Per-slot type tables and the decoded command fields
  logic [TYPE_W-1:0] sim_type_r [SLOTS];
  logic [TYPE_W-1:0] eff_type [SLOTS];
  logic [TYPE_W-1:0] phys_type [SLOTS];
  logic [3:0] cmd_slot_d;
  logic [2:0] cmd_slot;
  logic [CH_W-1:0] cmd_ch;
  logic digits_ok;
  logic [CH_W-1:0] ch_last;
  logic close_ok;
  logic assign_ok;
  logic sys_valid_r;
  logic [2:0] sys_slot_r;
  logic [CH_W-1:0] sys_ch_r;
  logic [CODE_W-1:0] sys_code_r;

  // Effective slot type: a real module always wins over a simulated one
  for (genvar gs = 0; gs < SLOTS; gs++) begin : g_type
    assign phys_type[gs] = phys_sync_r[gs*TYPE_W +: TYPE_W];
    assign eff_type[gs] = (phys_type[gs] != TYPE_NONE) ? phys_type[gs] : sim_type_r[gs];
  end

  // Split the three-digit code into slot and channel
  assign cmd_slot_d = slot_channel_code[11:8];
  assign cmd_slot = slot_idx(cmd_slot_d);
  assign cmd_ch = bcd_chan(slot_channel_code[7:0]);
  assign digits_ok = slot_ok(cmd_slot_d) && (slot_channel_code[7:4] <= DIGIT_MAX)
                     && (slot_channel_code[3:0] <= DIGIT_MAX);
  // Four-wire narrows the system range so channel n plus ten stays free
  assign ch_last = four_wire ? MEAS_LAST_4W : MEAS_LAST_2W;
  // Isolation, pole and missing channels never qualify
  assign close_ok = digits_ok && (eff_type[cmd_slot] == TYPE_MEAS20)
                    && (cmd_ch != 7'h00) && (cmd_ch <= ch_last);
  assign assign_ok = cmd_remote && slot_ok(cmd_slot_d)
                     && (phys_type[cmd_slot] == TYPE_NONE)
                     && (cmd_sim_type != TYPE_NONE);

  // ----------------------------------------------------------------
  // Simulated module table
  // ----------------------------------------------------------------
  // Held only in flops; power-off reset empties every slot
  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      for (int i = 0; i < SLOTS; i++) begin
        sim_type_r[i] <= TYPE_NONE;
      end
    end else if (cmd_valid && (cmd_op == OP_ASSIGN) && assign_ok) begin
      sim_type_r[cmd_slot] <= cmd_sim_type;
    end
  end

  // Occupancy lamps follow real or simulated presence
  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      slot_lamp_r <= '0;
    end else begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_lamp_r[i] <= (eff_type[i] != TYPE_NONE);
      end
    end
  end

  // ----------------------------------------------------------------
  // System channel register
  // ----------------------------------------------------------------
  // High when the held channel can no longer be routed to the meter
  logic sys_lost;

  // Channel becomes unusable if its module vanishes or falls outside 4W range
  assign sys_lost = sys_valid_r && ((eff_type[sys_slot_r] != TYPE_MEAS20)
                    || (four_wire && (sys_ch_r > MEAS_LAST_4W)));

  // Single slot holds the one system channel; a new close overwrites it
  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      sys_valid_r <= 1'b0;
      sys_slot_r <= '0;
      sys_ch_r <= '0;
      sys_code_r <= '0;
    end else if (cmd_valid && (cmd_op == OP_OPEN_ALL)) begin
      sys_valid_r <= 1'b0;
    end else if (cmd_valid && (cmd_op == OP_CLOSE) && close_ok) begin
      sys_valid_r <= 1'b1;
      sys_slot_r <= cmd_slot;
      sys_ch_r <= cmd_ch;
      sys_code_r <= slot_channel_code;
    end else if (sys_lost) begin
      sys_valid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Relay drive
  // ----------------------------------------------------------------
  // One drive word per slot, next value and register
  localparam logic [RELAY_N-1:0] ONE = 25'h0000001;
  logic [RELAY_N-1:0] relay_nxt [SLOTS];
  logic [RELAY_N-1:0] relay_r [SLOTS];

  // Relays are rebuilt from the system channel each cycle, so replacing
  // the channel opens the old set with no break-before-make gap logic
  for (genvar gs = 0; gs < SLOTS; gs++) begin : g_relay
    always_comb begin
      relay_nxt[gs] = '0;
      if (sys_valid_r && (sys_slot_r == 3'(gs))) begin
        relay_nxt[gs] = (ONE << 7'(sys_ch_r - 7'h01))
                        | (ONE << 7'(INPUT_ISO_CH - 7'h01));
        if (four_wire) begin
          relay_nxt[gs] = relay_nxt[gs]
                          | (ONE << 7'(sys_ch_r + PAIR_OFS - 7'h01))
                          | (ONE << 7'(SENSE_ISO_CH - 7'h01))
                          | (ONE << 7'(POLE_ISO_CH - 7'h01));
        end
      end
      // Two-wire leaves pair, sense and pole relays clear above
    end

    // Open-all clears at once rather than waiting for the channel to drop
    always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
        relay_r[gs] <= '0;
      end else if (cmd_valid && (cmd_op == OP_OPEN_ALL)) begin
        relay_r[gs] <= '0;
      end else begin
        relay_r[gs] <= relay_nxt[gs];
      end
    end

    // Slot k packs from bit k*25 upward, channel n at bit n-1
    assign relay_on[gs*RELAY_N +: RELAY_N] = relay_r[gs];
  end

  // ----------------------------------------------------------------
  // Display of the system channel
  // ----------------------------------------------------------------
  // Only the system code is shown; the paired channel never reaches here
  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      disp_chan_valid_r <= 1'b0;
      disp_chan_r <= '0;
    end else begin
      disp_chan_valid_r <= sys_valid_r;
      disp_chan_r <= sys_valid_r ? sys_code_r : '0;
    end
  end

  // ----------------------------------------------------------------
  // Command status and errors
  // ----------------------------------------------------------------
  // Remote close failures report the range error; other refusals only pulse reject
  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      cmd_done_r <= 1'b0;
      cmd_reject_r <= 1'b0;
      err_valid_r <= 1'b0;
      err_code_r <= '0;
    end else begin
      cmd_done_r <= 1'b0;
      cmd_reject_r <= 1'b0;
      err_valid_r <= 1'b0;
      if (cmd_valid) begin
        // The unused op code falls to the plain reject pulse
        unique case (cmd_op)
          OP_CLOSE: begin
            cmd_done_r <= close_ok;
            cmd_reject_r <= !close_ok;
            if (!close_ok && cmd_remote) begin
              err_valid_r <= 1'b1;
              err_code_r <= ERR_PARAM_RANGE;
            end
          end
          OP_OPEN_ALL: begin
            cmd_done_r <= 1'b1;
          end
          OP_ASSIGN: begin
            cmd_done_r <= assign_ok;
            cmd_reject_r <= !assign_ok;
          end
          default: begin
            cmd_reject_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  // Idle waits for a trigger, busy waits for the meter's done pulse
  scrc_meas_state_t meas_state_r;

  // Triggers arriving while busy are ignored; the meter handles one at a time
  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      meas_state_r <= SCRC_MEAS_IDLE;
      meas_start_r <= 1'b0;
      meas_chan_r <= '0;
    end else begin
      meas_start_r <= 1'b0;
      unique case (meas_state_r)
        SCRC_MEAS_IDLE: begin
          if (trigger && sys_valid_r) begin
            meas_start_r <= 1'b1;
            meas_chan_r <= sys_code_r;
            meas_state_r <= SCRC_MEAS_BUSY;
          end
        end
        SCRC_MEAS_BUSY: begin
          if (meas_done) begin
            meas_state_r <= SCRC_MEAS_IDLE;
          end
        end
      endcase
    end
  end

  // Result latched for the display when the meter reports completion
  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      disp_value_valid_r <= 1'b0;
      disp_value_r <= '0;
    end else if ((meas_state_r == SCRC_MEAS_BUSY) && meas_done) begin
      disp_value_valid_r <= 1'b1;
      disp_value_r <= meas_value;
    end
  end

endmodule
`default_nettype wire

/* include/scrc_pkg.sv */
// Constants and types shared by the channel relay control block
`default_nettype none
package scrc_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int SLOTS = 5;
  localparam int RELAY_N = 25;
  localparam int CH_W = 7;
  localparam int TYPE_W = 2;
  localparam int CODE_W = 12;
  localparam int OP_W = 2;
  localparam int VAL_W = 24;
  localparam int ERR_W = 16;

  // ----------------------------------------------------------------
  // Module types seen in a slot
  // ----------------------------------------------------------------
  localparam logic [TYPE_W-1:0] TYPE_NONE = 2'h0;
  localparam logic [TYPE_W-1:0] TYPE_MEAS20 = 2'h1;
  localparam logic [TYPE_W-1:0] TYPE_NONMEAS = 2'h2;

  // ----------------------------------------------------------------
  // Channel numbers on the twenty-channel module
  // ----------------------------------------------------------------
  localparam logic [CH_W-1:0] MEAS_LAST_2W = 7'h14;
  localparam logic [CH_W-1:0] MEAS_LAST_4W = 7'h0a;
  localparam logic [CH_W-1:0] PAIR_OFS = 7'h0a;
  localparam logic [CH_W-1:0] POLE_ISO_CH = 7'h17;
  localparam logic [CH_W-1:0] SENSE_ISO_CH = 7'h18;
  localparam logic [CH_W-1:0] INPUT_ISO_CH = 7'h19;
  localparam logic [3:0] SLOT_FIRST = 4'h1;
  localparam logic [3:0] SLOT_LAST = 4'h5;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  // ----------------------------------------------------------------
  // Commands and error code
  // ----------------------------------------------------------------
  localparam logic [OP_W-1:0] OP_CLOSE = 2'h0;
  localparam logic [OP_W-1:0] OP_OPEN_ALL = 2'h1;
  localparam logic [OP_W-1:0] OP_ASSIGN = 2'h2;
  localparam logic [ERR_W-1:0] ERR_PARAM_RANGE = 16'hff22;

  // ----------------------------------------------------------------
  // Measurement sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SCRC_MEAS_IDLE = 1'b0,
    SCRC_MEAS_BUSY = 1'b1
  } scrc_meas_state_t;
endpackage
`default_nettype wire

/* dv/scrc_top_assertions.sv */
// Checker for the channel relay control block ports
`default_nettype none
module scrc_top_assertions
  import scrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic four_wire,
  input wire logic cmd_valid,
  input wire logic cmd_remote,
  input wire logic [OP_W-1:0] cmd_op,
  input wire logic [CODE_W-1:0] slot_channel_code,
  input wire logic [SLOTS*RELAY_N-1:0] relay_on,
  input wire logic [SLOTS-1:0] slot_lamp_r,
  input wire logic disp_chan_valid_r,
  input wire logic [CODE_W-1:0] disp_chan_r,
  input wire logic meas_start_r,
  input wire logic [CODE_W-1:0] meas_chan_r,
  input wire logic cmd_done_r,
  input wire logic cmd_reject_r,
  input wire logic err_valid_r,
  input wire logic [ERR_W-1:0] err_code_r
);
  // ----------------------------------------------------------------
  // Relay group views
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [SLOTS-1:0] iso_ok;
  logic [SLOTS-1:0] pole_ok;
  logic [SLOTS-1:0] fw_bits;
  logic [2:0] code_slot;
  // Zero-based slot named by the command code
  assign code_slot = 3'(slot_channel_code[11:8] - 4'h1);
  // Per slot: channel needs input isolation, sense and pole move together
  always_comb begin
    for (int s = 0; s < SLOTS; s++) begin
      iso_ok[s] = !(|relay_on[s*RELAY_N +: 20]) || relay_on[s*RELAY_N+24];
      pole_ok[s] = relay_on[s*RELAY_N+22] == relay_on[s*RELAY_N+23];
      fw_bits[s] = relay_on[s*RELAY_N+22] | relay_on[s*RELAY_N+23];
    end
  end
  cmd_answer_a: assert property (cmd_valid |=> cmd_done_r != cmd_reject_r)
    else $error("command not answered once");
  open_relays_a: assert property (cmd_valid && cmd_op == OP_OPEN_ALL |=> relay_on == '0)
    else $error("open all left a relay closed");
  open_disp_a: assert property (cmd_valid && cmd_op == OP_OPEN_ALL |=> ##1 !disp_chan_valid_r)
    else $error("channel shown after open all");
  reject_hold_a: assert property (cmd_reject_r |=> $stable(relay_on))
    else $error("relays moved on a refused command");
  err_code_a: assert property (err_valid_r |-> cmd_reject_r && err_code_r == ERR_PARAM_RANGE)
    else $error("bad error report");
  front_err_a: assert property (cmd_valid && !cmd_remote |=> !err_valid_r)
    else $error("front panel command raised error");
  input_iso_a: assert property (&iso_ok)
    else $error("channel closed without input isolation");
  sense_pole_a: assert property (&pole_ok)
    else $error("sense and pole relays disagree");
  two_wire_a: assert property (!four_wire [*3] |-> fw_bits == '0)
    else $error("four wire relay closed in two wire mode");
  single_chan_a: assert property ($countones(relay_on) <= 5)
    else $error("more than one system channel");
  meas_chan_a: assert property (meas_start_r |-> disp_chan_valid_r && meas_chan_r == disp_chan_r)
    else $error("measurement on wrong channel");
  assign_lamp_a: assert property (cmd_valid && cmd_op == OP_ASSIGN ##1 cmd_done_r
    |=> slot_lamp_r[$past(code_slot, 2)])
    else $error("lamp dark after assign");
  cover property (cmd_valid && four_wire && cmd_op == OP_CLOSE);
  cover property (err_valid_r);
  cover property (meas_start_r);
endmodule
bind scrc_top scrc_top_assertions u_chk (.core_clk, .rst_n, .four_wire, .cmd_valid, .cmd_remote,
  .cmd_op, .slot_channel_code, .relay_on, .slot_lamp_r, .disp_chan_valid_r, .disp_chan_r,
  .meas_start_r,
  .meas_chan_r, .cmd_done_r, .cmd_reject_r, .err_valid_r, .err_code_r);
`default_nettype wire

/* dv/scrc_partner.sv */
// Slot modules and meter model facing the relay control block
`default_nettype none
module scrc_partner
  import scrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic meas_start_r,
  input wire logic [CODE_W-1:0] meas_chan_r,
  output logic [SLOTS*TYPE_W-1:0] phys_type_pin,
  output logic meas_done,
  output logic [VAL_W-1:0] meas_value
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Slots and meter
  // ----------------------------------------------------------------
  // Slot 1 twenty-channel, slot 3 non-measurement, others empty
  assign phys_type_pin = {4'h0, TYPE_NONMEAS, TYPE_NONE, TYPE_MEAS20};
  // Meter answers four cycles late at the falling edge; value scrambled outside done
  initial begin
    meas_done = 1'b0;
    meas_value = 24'h000000;
    forever begin
      @(negedge core_clk);
      if (meas_start_r) begin
        repeat (4) @(negedge core_clk);
        meas_done = 1'b1;
        meas_value = {12'h5a5, meas_chan_r};
        @(negedge core_clk);
        meas_done = 1'b0;
        meas_value = ~meas_value;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/scrc_top_tb.sv */
// Self-checking bench for the channel relay control block
`default_nettype none
module scrc_top_tb
  import scrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic four_wire = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_remote = 1'b0;
  logic trigger = 1'b0;
  logic [OP_W-1:0] cmd_op = 2'h0;
  logic [CODE_W-1:0] slot_channel_code = 12'h000;
  logic [TYPE_W-1:0] cmd_sim_type = 2'h0;
  logic [SLOTS*TYPE_W-1:0] phys_type_pin;
  logic [SLOTS*RELAY_N-1:0] relay_on;
  logic [SLOTS-1:0] slot_lamp_r;
  logic [VAL_W-1:0] meas_value, disp_value_r;
  logic [CODE_W-1:0] disp_chan_r, meas_chan_r;
  logic [ERR_W-1:0] err_code_r;
  logic meas_done, disp_chan_valid_r, disp_value_valid_r, meas_start_r;
  logic cmd_done_r, cmd_reject_r, err_valid_r;
  int miscompares = 0;
  int checked = 0;
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  scrc_top DUT (.core_clk, .rst_n, .phys_type_pin, .four_wire, .cmd_valid, .cmd_remote, .cmd_op,
    .slot_channel_code, .cmd_sim_type, .trigger, .meas_done, .meas_value, .relay_on,
    .slot_lamp_r, .disp_chan_valid_r, .disp_chan_r, .disp_value_valid_r, .disp_value_r,
    .meas_start_r, .meas_chan_r, .cmd_done_r, .cmd_reject_r, .err_valid_r, .err_code_r);
  scrc_partner u_far (.core_clk, .meas_start_r, .meas_chan_r, .phys_type_pin, .meas_done,
    .meas_value);
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [SLOTS*RELAY_N-1:0] exp, logic [SLOTS*RELAY_N-1:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Expected relay image of one system channel
  function automatic logic [SLOTS*RELAY_N-1:0] rel(int s, int ch, logic fw);
    int b;
    b = (s - 1) * RELAY_N - 1;
    rel = '0;
    rel[b+ch] = 1'b1;
    rel[b+INPUT_ISO_CH] = 1'b1;
    if (fw) begin
      rel[b+ch+PAIR_OFS] = 1'b1;
      rel[b+SENSE_ISO_CH] = 1'b1;
      rel[b+POLE_ISO_CH] = 1'b1;
    end
  endfunction
  // One command; returns once relays and lamps have settled
  task automatic cmd(logic [OP_W-1:0] op, logic [CODE_W-1:0] c, logic rem, logic ok, logic err);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    slot_channel_code = c;
    cmd_remote = rem;
    // Status pulses stand only in the cycle after the taking edge
    @(negedge core_clk);
    chk("done", ok, cmd_done_r);
    chk("reject", !ok, cmd_reject_r);
    chk("error", err, err_valid_r);
    if (err) chk("err code", ERR_PARAM_RANGE, err_code_r);
    cmd_valid = 1'b0;
    @(negedge core_clk);
  endtask
  // Returns while the start pulse stands
  task automatic pulse_trig();
    @(negedge core_clk);
    trigger = 1'b1;
    @(negedge core_clk);
    trigger = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_two_wire();
    cmd(OP_CLOSE, 12'h101, 1'b1, 1'b1, 1'b0);
    chk("relays 101", rel(1, 1, 1'b0), relay_on);
    chk("disp 101", {1'b1, 12'h101}, {disp_chan_valid_r, disp_chan_r});
    cmd(OP_CLOSE, 12'h120, 1'b1, 1'b1, 1'b0);
    chk("relays 120", rel(1, 20, 1'b0), relay_on);
  endtask
  task automatic t_four_wire();
    four_wire = 1'b1;
    cmd(OP_CLOSE, 12'h110, 1'b1, 1'b1, 1'b0);
    chk("relays 4w", rel(1, 10, 1'b1), relay_on);
    chk("disp 110", {1'b1, 12'h110}, {disp_chan_valid_r, disp_chan_r});
    cmd(OP_CLOSE, 12'h111, 1'b1, 1'b0, 1'b1);
    four_wire = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("back to 2w", rel(1, 10, 1'b0), relay_on);
  endtask
  task automatic t_reject();
    logic [CODE_W-1:0] bad [7] = '{12'h100, 12'h121, 12'h301, 12'h601, 12'h10a, 12'h201,
      12'h001};
    foreach (bad[i]) begin
      cmd(OP_CLOSE, bad[i], 1'b1, 1'b0, 1'b1);
      chk("relays kept", rel(1, 10, 1'b0), relay_on);
    end
    cmd(OP_CLOSE, 12'h121, 1'b0, 1'b0, 1'b0);
    cmd(2'h3, 12'h101, 1'b1, 1'b0, 1'b0);
    chk("relays op3", rel(1, 10, 1'b0), relay_on);
  endtask
  task automatic t_assign();
    cmd_sim_type = TYPE_MEAS20;
    cmd(OP_ASSIGN, 12'h200, 1'b0, 1'b0, 1'b0);
    cmd(OP_ASSIGN, 12'h100, 1'b1, 1'b0, 1'b0);
    cmd(OP_ASSIGN, 12'h600, 1'b1, 1'b0, 1'b0);
    chk("lamp off", 1'b0, slot_lamp_r[1]);
    cmd_sim_type = TYPE_NONE;
    cmd(OP_ASSIGN, 12'h400, 1'b1, 1'b0, 1'b0);
    chk("lamp 4 off", 1'b0, slot_lamp_r[3]);
    cmd_sim_type = TYPE_MEAS20;
    cmd(OP_ASSIGN, 12'h200, 1'b1, 1'b1, 1'b0);
    chk("lamp on", 1'b1, slot_lamp_r[1]);
    cmd(OP_CLOSE, 12'h205, 1'b1, 1'b1, 1'b0);
    chk("relays 205", rel(2, 5, 1'b0), relay_on);
  endtask
  task automatic t_measure();
    pulse_trig();
    chk("start", 1'b1, meas_start_r);
    chk("meas chan", 12'h205, meas_chan_r);
    pulse_trig();
    chk("busy ignored", 1'b0, meas_start_r);
    for (int i = 0; i < 20 && disp_value_valid_r !== 1'b1; i++)
      @(negedge core_clk);
    chk("value valid", 1'b1, disp_value_valid_r);
    chk("value", {12'h5a5, 12'h205}, disp_value_r);
  endtask
  task automatic t_open_all();
    cmd(OP_OPEN_ALL, 12'h000, 1'b1, 1'b1, 1'b0);
    chk("open all", '0, relay_on);
    chk("no channel", 1'b0, disp_chan_valid_r);
    pulse_trig();
    chk("no start", 1'b0, meas_start_r);
  endtask
  // Power loss must forget the simulated slot
  task automatic t_power_off();
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("lamp lost", 1'b0, slot_lamp_r[1]);
    cmd(OP_CLOSE, 12'h201, 1'b1, 1'b0, 1'b1);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_two_wire();
    t_four_wire();
    t_reject();
    t_assign();
    t_measure();
    t_open_all();
    t_power_off();
    test_done();
  end
  // Watchdog: run needs about a hundred cycles
  initial begin
    #100us;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
